// file: nsf_feature_regs.sv
`timescale 1ns/10ps
`include "nsf_cfg.svh"

module nsf_feature_regs (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    sclk_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    si_i,
    output logic                         so_o,
    output logic                         so_oe_o,
    output nsf_pkg::nsf_core_req_t       core_req_o,
    input  wire nsf_pkg::nsf_core_resp_t core_resp_i,
    input  wire logic [11:0]             col_addr_i,
    output logic                         col_write_allow_o,
    output logic                         col_ecc_prot_o,
    output logic                         ecc_en_o,
    output logic [1:0]                   drive_sel_o
);

    // link side signals
    logic [5:0]           bit_cnt_reg;
    logic [5:0]           bit_cnt_next;
    logic [31:0]          sh_in_reg;
    logic [31:0]          sh_in_next;
    logic [7:0]           opcode_reg;
    logic                 trig;
    logic                 rd_load;
    nsf_pkg::nsf_frame_t  frame_reg;
    logic                 tog_reg;
    logic                 req_s1_reg, req_s2_reg, img_ack_reg;
    logic [31:0]          rd_s2_reg;
    logic [7:0]           rd_addr_reg;
    logic [7:0]           out_sh_reg;
    logic [2:0]           ph_reg;
    logic                 rd_act_reg;

    // core side signals
    logic                 t_s1_reg;
    logic                 t_s2_reg;
    logic                 t_s3_reg;
    logic                 ev;
    nsf_pkg::nsf_state_t  state_reg;
    nsf_pkg::nsf_op_t     cur_op_reg;
    logic                 write_latch_flag;
    logic                 prog_fail_reg;
    logic                 wipe_fail_reg;
    logic                 ecc_state_hi;
    logic                 ecc_state_lo;
    logic                 ecc_count_hi;
    logic                 ecc_count_lo;
    logic                 op_in_progress_flag;
    logic [31:0]          pub_reg, hold_reg;
    logic                 pub_req_reg, ack_s1_reg, ack_s2_reg;
    logic [7:0]           feat_byte;
    logic [7:0]           stat_byte;
    logic [7:0]           drv_byte;
    logic [7:0]           ext_byte;
    logic                 ev_lset;
    logic                 ev_lclr;
    logic                 ev_setf;
    logic                 ev_rst;
    logic                 go_fetch;
    logic                 go_prog;
    logic                 go_wipe;
    logic                 done;
    logic                 idle;

    // picks one feature byte from the image {b0, c0, d0, f0}
    function automatic logic [7:0] feat_pick(input logic [31:0] img, input logic [7:0] a);
        if (a == `NSF_FA_FEATURE)
            return img[31:24];
        else if (a == `NSF_FA_STATUS)
            return img[23:16];
        else if (a == `NSF_FA_DRIVE)
            return img[15:8];
        else if (a == `NSF_FA_EXT)
            return img[7:0];
        else
            return 8'h00;
    endfunction

    // maps a corrected-bit count to {state, count}
    function automatic logic [3:0] ecc_code(input logic unc, input logic [3:0] n);
        logic [3:0] m;
        m = n - `NSF_ECC_LOWCNT;
        if (unc || n > `NSF_ECC_CAP)
            return {`NSF_ECCS_UNCORR, 2'b00};
        else if (n == `NSF_ECC_CAP)
            return {`NSF_ECCS_MAX, 2'b00};
        else if (n == 4'h0)
            return {`NSF_ECCS_NONE, 2'b00};
        else if (n <= `NSF_ECC_LOWCNT)
            return {`NSF_ECCS_CORR, 2'b00};
        else
            return {`NSF_ECCS_CORR, m[1:0]};
    endfunction

    // frame decode; counter saturates so long frames never retrigger
    assign sh_in_next   = {sh_in_reg[30:0], si_i};
    assign bit_cnt_next = (bit_cnt_reg == 6'h3f) ? bit_cnt_reg : bit_cnt_reg + 6'h01;
    assign rd_load      = (bit_cnt_next == `NSF_LEN_GETF) && (opcode_reg == `NSF_CMD_GETF);

    // command completes on its last opcode, address or data bit
    always_comb begin
        trig = 1'b0;
        if (bit_cnt_next == `NSF_LEN_CMD) begin
            trig = (sh_in_next[7:0] == `NSF_CMD_LSET) || (sh_in_next[7:0] == `NSF_CMD_LCLR)
                || (sh_in_next[7:0] == `NSF_CMD_RESET);
        end else if (bit_cnt_next == `NSF_LEN_SETF) begin
            trig = (opcode_reg == `NSF_CMD_SETF);
        end else if (bit_cnt_next == `NSF_LEN_ROW) begin
            trig = (opcode_reg == `NSF_CMD_FETCH) || (opcode_reg == `NSF_CMD_PROG)
                || (opcode_reg == `NSF_CMD_WIPE);
        end
    end

    // shift-in; chip select high ends the frame without a clock edge
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_reg <= 6'h00;
            sh_in_reg   <= 32'h0000_0000;
            opcode_reg  <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            sh_in_reg   <= sh_in_next;
            if (bit_cnt_next == `NSF_LEN_CMD) begin
                opcode_reg <= sh_in_next[7:0];
            end
        end
    end

    // toggle plus held frame; frame is stable long before the toggle is seen
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            tog_reg   <= 1'b0;
            frame_reg <= '0;
        end else if (trig) begin
            tog_reg          <= ~tog_reg;
            frame_reg.opcode <= (bit_cnt_next == `NSF_LEN_CMD) ? sh_in_next[7:0] : opcode_reg;
            frame_reg.arg    <= sh_in_next[23:0];
        end
    end

    // image crossing, link side; only advances while the host clocks
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            {req_s1_reg, req_s2_reg, img_ack_reg, rd_s2_reg} <= 35'h0;
        end else begin
            {req_s1_reg, req_s2_reg} <= {pub_req_reg, req_s1_reg};
            if (req_s2_reg != img_ack_reg)
                {img_ack_reg, rd_s2_reg} <= {req_s2_reg, hold_reg};
        end
    end

    // get-feature output, byte reloaded every 8 bits so status can be polled
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rd_act_reg  <= 1'b0;
            ph_reg      <= 3'h0;
            rd_addr_reg <= 8'h00;
            out_sh_reg  <= 8'h00;
        end else if (rd_load) begin
            rd_act_reg  <= 1'b1;
            ph_reg      <= 3'h0;
            rd_addr_reg <= sh_in_next[7:0];
            out_sh_reg  <= feat_pick(rd_s2_reg, sh_in_next[7:0]);
        end else if (rd_act_reg) begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h7)
                out_sh_reg <= feat_pick(rd_s2_reg, rd_addr_reg);
            else
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
    end

    // data out changes on the falling edge for the host's rising-edge sample
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_o    <= out_sh_reg[7];
            so_oe_o <= rd_act_reg;
        end
    end

    // frame event into the core clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_s1_reg <= 1'b0;
            t_s2_reg <= 1'b0;
            t_s3_reg <= 1'b0;
        end else begin
            t_s1_reg <= tog_reg;
            t_s2_reg <= t_s1_reg;
            t_s3_reg <= t_s2_reg;
        end
    end

    // command decode in the core clock
    assign ev       = t_s2_reg ^ t_s3_reg;
    assign idle     = (state_reg == nsf_pkg::ST_IDLE);
    assign ev_lset  = ev && (frame_reg.opcode == `NSF_CMD_LSET);
    assign ev_lclr  = ev && (frame_reg.opcode == `NSF_CMD_LCLR);
    assign ev_setf  = ev && (frame_reg.opcode == `NSF_CMD_SETF);
    assign ev_rst   = ev && (frame_reg.opcode == `NSF_CMD_RESET) && (state_reg != nsf_pkg::ST_BOOT);
    assign go_fetch = ev && (frame_reg.opcode == `NSF_CMD_FETCH) && idle;
    assign go_prog  = ev && (frame_reg.opcode == `NSF_CMD_PROG) && idle && write_latch_flag;
    assign go_wipe  = ev && (frame_reg.opcode == `NSF_CMD_WIPE) && idle && write_latch_flag;
    assign done     = core_resp_i.done && (state_reg == nsf_pkg::ST_BUSY);
    assign op_in_progress_flag = !idle;

    // operation sequencer; power-on does a fetch of block 0 page 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= nsf_pkg::ST_BOOT;
            cur_op_reg <= nsf_pkg::OP_FETCH;
            core_req_o <= '0;
        end else begin
            core_req_o.start <= 1'b0;
            case (state_reg)
                nsf_pkg::ST_BOOT: begin
                    core_req_o <= '{1'b1, nsf_pkg::OP_FETCH, 24'h000000};
                    cur_op_reg <= nsf_pkg::OP_FETCH;
                    state_reg  <= nsf_pkg::ST_BUSY;
                end
                nsf_pkg::ST_IDLE: begin
                    if (ev_rst) begin
                        core_req_o <= '{1'b1, nsf_pkg::OP_RESET, 24'h000000};
                        cur_op_reg <= nsf_pkg::OP_RESET;
                        state_reg  <= nsf_pkg::ST_BUSY;
                    end else if (go_fetch) begin
                        core_req_o <= '{1'b1, nsf_pkg::OP_FETCH, frame_reg.arg};
                        cur_op_reg <= nsf_pkg::OP_FETCH;
                        state_reg  <= nsf_pkg::ST_BUSY;
                    end else if (go_prog) begin
                        core_req_o <= '{1'b1, nsf_pkg::OP_PROG, frame_reg.arg};
                        cur_op_reg <= nsf_pkg::OP_PROG;
                        state_reg  <= nsf_pkg::ST_BUSY;
                    end else if (go_wipe) begin
                        core_req_o <= '{1'b1, nsf_pkg::OP_WIPE, frame_reg.arg};
                        cur_op_reg <= nsf_pkg::OP_WIPE;
                        state_reg  <= nsf_pkg::ST_BUSY;
                    end
                end
                nsf_pkg::ST_BUSY: begin
                    // a reset command aborts the running operation
                    if (ev_rst) begin
                        core_req_o <= '{1'b1, nsf_pkg::OP_RESET, 24'h000000};
                        cur_op_reg <= nsf_pkg::OP_RESET;
                    end else if (core_resp_i.done) begin
                        state_reg <= nsf_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= nsf_pkg::ST_IDLE;
            endcase
        end
    end

    // write latch
    always_ff @(posedge clk_i) begin
        if (rst_i)
            write_latch_flag <= 1'b0;
        else if (ev_lset)
            write_latch_flag <= 1'b1;
        else if (ev_lclr)
            write_latch_flag <= 1'b0;
    end

    // fail flags; a completion in the clearing cycle still sets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_fail_reg <= 1'b0;
            wipe_fail_reg <= 1'b0;
        end else begin
            if (go_prog || ev_rst)
                prog_fail_reg <= 1'b0;
            if (go_wipe || ev_rst)
                wipe_fail_reg <= 1'b0;
            if (done && cur_op_reg == nsf_pkg::OP_PROG && core_resp_i.fail)
                prog_fail_reg <= 1'b1;
            if (done && cur_op_reg == nsf_pkg::OP_WIPE && core_resp_i.fail)
                wipe_fail_reg <= 1'b1;
        end
    end

    // ecc result; cleared by a fetch but not loaded while ecc is off since it means nothing then
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {ecc_state_hi, ecc_state_lo, ecc_count_hi, ecc_count_lo} <= 4'h0;
        end else begin
            if (go_fetch || ev_rst)
                {ecc_state_hi, ecc_state_lo, ecc_count_hi, ecc_count_lo} <= 4'h0;
            if (done && cur_op_reg == nsf_pkg::OP_FETCH && ecc_en_o)
                {ecc_state_hi, ecc_state_lo, ecc_count_hi, ecc_count_lo}
                    <= ecc_code(core_resp_i.uncorr, core_resp_i.err_cnt);
        end
    end

    // writable features; status addresses ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ecc_en_o    <= `NSF_ECCEN_RST;
            drive_sel_o <= `NSF_DS_RST;
        end else if (ev_setf) begin
            if (frame_reg.arg[15:8] == `NSF_FA_FEATURE)
                ecc_en_o <= frame_reg.arg[`NSF_ECCEN_BIT];
            else if (frame_reg.arg[15:8] == `NSF_FA_DRIVE)
                drive_sel_o <= frame_reg.arg[`NSF_DS_HI_BIT:`NSF_DS_LO_BIT];
        end
    end

    // readable image; reserved bits zero, no read side effects
    always_comb begin
        feat_byte = 8'h00;
        stat_byte = 8'h00;
        drv_byte  = 8'h00;
        ext_byte  = 8'h00;
        feat_byte[`NSF_ECCEN_BIT]  = ecc_en_o;
        stat_byte[`NSF_BUSY_BIT]   = op_in_progress_flag;
        stat_byte[`NSF_LATCH_BIT]  = write_latch_flag;
        stat_byte[`NSF_EFAIL_BIT]  = wipe_fail_reg;
        stat_byte[`NSF_PFAIL_BIT]  = prog_fail_reg;
        stat_byte[`NSF_ECC_HI_BIT] = ecc_state_hi;
        stat_byte[`NSF_ECC_LO_BIT] = ecc_state_lo;
        ext_byte[`NSF_ECC_HI_BIT]  = ecc_count_hi;
        ext_byte[`NSF_ECC_LO_BIT]  = ecc_count_lo;
        drv_byte[`NSF_DS_HI_BIT]   = drive_sel_o[1];
        drv_byte[`NSF_DS_LO_BIT]   = drive_sel_o[0];
    end

    // image crossing, core side; hold moves only after the link side took the last word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {pub_reg, hold_reg, pub_req_reg, ack_s1_reg, ack_s2_reg} <= 67'h0;
        end else begin
            pub_reg <= {feat_byte, stat_byte, drv_byte, ext_byte};
            {ack_s1_reg, ack_s2_reg} <= {img_ack_reg, ack_s1_reg};
            if (ack_s2_reg == pub_req_reg)
                {pub_req_reg, hold_reg} <= {~pub_req_reg, pub_reg};
        end
    end

    // page map for the load and ecc paths, one cycle behind col_addr_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_write_allow_o <= 1'b1;
            col_ecc_prot_o    <= 1'b0;
        end else begin
            col_write_allow_o <= !(ecc_en_o && col_addr_i >= `NSF_PAR_LO
                                   && col_addr_i <= `NSF_PAR_HI);
            col_ecc_prot_o <= ecc_en_o && ((col_addr_i <= `NSF_MAIN_END)
                || (col_addr_i >= `NSF_PAR_LO && col_addr_i <= `NSF_PAR_HI)
                || (col_addr_i <= `NSF_PAR_HI && col_addr_i[3:0] > `NSF_SEG_OPEN));
        end
    end

    // checks in the core clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_latch_set: assert property (ev_lset |=> write_latch_flag)
        else $error("write latch not set");
    a_latch_clr: assert property (ev_lclr && !ev_lset |=> !write_latch_flag)
        else $error("write latch not cleared");
    a_pfail_clr: assert property (go_prog |=> !prog_fail_reg ##1 op_in_progress_flag)
        else $error("program fail not cleared at start");
    a_wfail_clr: assert property (ev_rst && !(done && core_resp_i.fail)
        |=> !wipe_fail_reg && !prog_fail_reg)
        else $error("fail flags kept after reset command");
    a_pfail_set: assert property (done && cur_op_reg == nsf_pkg::OP_PROG && core_resp_i.fail
        |=> prog_fail_reg && (op_in_progress_flag == $past(ev_rst)))
        else $error("program failure lost");
    a_wfail_set: assert property (done && cur_op_reg == nsf_pkg::OP_WIPE && core_resp_i.fail
        |=> wipe_fail_reg)
        else $error("erase failure lost");
    a_busy_start: assert property (core_req_o.start |-> op_in_progress_flag
        ##1 op_in_progress_flag)
        else $error("busy not shown during operation");
    a_ecc_clear: assert property (go_fetch |=> {ecc_state_hi, ecc_state_lo} == 2'b00
        && core_req_o.start)
        else $error("ecc state not cleared at read start");
    a_ecc_off: assert property (!ecc_en_o && done && !ev_rst
        |=> $stable({ecc_state_hi, ecc_state_lo, ecc_count_hi, ecc_count_lo}))
        else $error("ecc fields updated while ecc off");
    a_drive_write: assert property (ev_setf && frame_reg.arg[15:8] == `NSF_FA_DRIVE
        |=> drive_sel_o == $past(frame_reg.arg[6:5]) ##1 pub_reg[14:13] == drive_sel_o)
        else $error("drive select not written");
    a_parity_drop: assert property (ecc_en_o && col_addr_i == `NSF_PAR_LO
        |=> !col_write_allow_o)
        else $error("parity write not blocked");

    c_read_done: cover property (go_fetch ##[1:1000] done);
    c_prog_fail: cover property (done && cur_op_reg == nsf_pkg::OP_PROG && core_resp_i.fail);
    c_reset_busy: cover property (ev_rst && state_reg == nsf_pkg::ST_BUSY);

endmodule

// file: nsf_cfg.svh
`ifndef NSF_CFG_SVH
`define NSF_CFG_SVH
`define NSF_FA_FEATURE  8'hb0
`define NSF_FA_STATUS   8'hc0
`define NSF_FA_DRIVE    8'hd0
`define NSF_FA_EXT      8'hf0
`define NSF_CMD_LSET    8'h06
`define NSF_CMD_LCLR    8'h04
`define NSF_CMD_GETF    8'h0f
`define NSF_CMD_SETF    8'h1f
`define NSF_CMD_FETCH   8'h13
`define NSF_CMD_PROG    8'h10
`define NSF_CMD_WIPE    8'hd8
`define NSF_CMD_RESET   8'hff
`define NSF_LEN_CMD     6'h08
`define NSF_LEN_GETF    6'h10
`define NSF_LEN_SETF    6'h18
`define NSF_LEN_ROW     6'h20
`define NSF_BUSY_BIT    0
`define NSF_LATCH_BIT   1
`define NSF_EFAIL_BIT   2
`define NSF_PFAIL_BIT   3
`define NSF_ECC_LO_BIT  4
`define NSF_ECC_HI_BIT  5
`define NSF_DS_LO_BIT   5
`define NSF_DS_HI_BIT   6
`define NSF_ECCEN_BIT   4
`define NSF_ECCEN_RST   1'b1
`define NSF_DS_RST      2'b00
`define NSF_ECCS_NONE   2'b00
`define NSF_ECCS_CORR   2'b01
`define NSF_ECCS_UNCORR 2'b10
`define NSF_ECCS_MAX    2'b11
`define NSF_ECC_CAP     4'h8
`define NSF_ECC_LOWCNT  4'h4
`define NSF_MAIN_END    12'h7ff
`define NSF_PAR_LO      12'h840
`define NSF_PAR_HI      12'h87f
`define NSF_SEG_OPEN    4'h3
`endif

// file: nsf_pkg.sv
package nsf_pkg;
    typedef enum {ST_BOOT, ST_IDLE, ST_BUSY} nsf_state_t;
    typedef enum logic [1:0] {OP_FETCH, OP_PROG, OP_WIPE, OP_RESET} nsf_op_t;
    // one decoded serial frame handed to the core clock
    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] arg;
    } nsf_frame_t;
    // array engine request and answer
    typedef struct packed {
        logic        start;
        nsf_op_t     op;
        logic [23:0] row;
    } nsf_core_req_t;
    typedef struct packed {
        logic       done;
        logic       fail;
        logic       uncorr;
        logic [3:0] err_cnt;
    } nsf_core_resp_t;
endpackage

// file: nsf_host_model.sv
`timescale 1ns/10ps
module nsf_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    // link clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end
    // one frame msb first; reply bits taken on rising edges after byte two
    task automatic frame(input logic [31:0] b, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #13 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = b[31-i];
            #20 sclk_o = 1'b1;
            if (i >= 16) rd = {rd[6:0], so_i};
            #40 sclk_o = 1'b0;
            #20;
        end
        cs_n_o = 1'b1;
        si_o   = ~si_o; // deselected, so no stale level
        #100;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    sclk, cs_n, si, so, oe, wa, pr, een;
    logic [1:0]              drv;
    nsf_pkg::nsf_core_req_t  req;
    nsf_pkg::nsf_core_resp_t resp = '0;
    logic [11:0]             col = 12'h000;
    logic [11:0]             cols [6] = '{12'h800, 12'h803, 12'h804, 12'h813, 12'h7ff, 12'h840};
    logic [3:0]              err = 4'h6;
    logic [31:0]             seed = 32'h1310;
    logic [7:0]              v, rd;
    logic                    fs = 1'b0;
    int                      fail_count = 0;
    int                      checks_done = 0;
    int                      cyc = 0;
    int                      wt = 0;
    int                      oe_cnt = 0;
    always #2 clk_i = ~clk_i;
    nsf_feature_regs i_nsf_feature_regs (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_o(oe), .core_req_o(req), .core_resp_i(resp), .col_addr_i(col),
        .col_write_allow_o(wa), .col_ecc_prot_o(pr), .ecc_en_o(een), .drive_sel_o(drv));
    nsf_host_model i_nsf_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    // link edges on which the reply is driven
    always @(posedge sclk) if (oe === 1'b1) oe_cnt++;
    // array engine stand-in; slow answer so busy can be read mid-operation
    always @(posedge clk_i) begin
        if (req.start === 1'b1) wt <= 600;
        else if (wt > 0) wt <= wt - 1;
        resp <= #1 {wt == 1, fs, err > 4'h8, err};
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            print_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {count, state} for a number of bit errors
    function automatic logic [3:0] xecc(input logic [3:0] e);
        if (e > 4'h8) return 4'b0010;
        if (e == 4'h8) return 4'b0011;
        if (e == 4'h0) return 4'b0000;
        return {(e > 4'h4) ? e[1:0] : 2'b00, 2'b01};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] x, input string m);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic get(input logic [7:0] a);
        oe_cnt = 0;
        i_nsf_host_model.frame({8'h0f, a, 16'h0000}, 24, v);
        chk(8'(oe_cnt), 8'h08, "reply window");
        chk({7'h00, oe}, 8'h00, "reply released");
    endtask
    task automatic cmd(input logic [31:0] f, input int n);
        i_nsf_host_model.frame(f, n, rd);
    endtask
    // array command, status read while busy, bounded wait for completion
    task automatic op(input logic [31:0] f, input int n, input logic [7:0] mid, input logic [7:0] fin);
        logic [1:0] xop;
        xop = (f[31:24] == 8'h10) ? 2'h1 : (f[31:24] == 8'hd8) ? 2'h2 : {2{f[31:24] == 8'hff}};
        cmd(f, n);
        get(8'hc0);
        chk(v, mid, "busy status");
        if (mid[0]) chk({6'h00, req.op}, {6'h00, xop}, "request op");
        if (mid[0]) chk(req.row[7:0], f[7:0], "request row");
        for (int i = 0; i < 2000 && resp.done !== 1'b1; i++) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        get(8'hc0);
        chk(v, fin, "final status");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= #1 1'b0;
        repeat (700) @(posedge clk_i);
        get(8'hc0);
        chk(v, 8'h10, "boot ecc");
        get(8'hb0);
        chk(v, 8'h10, "ecc on");
        get(8'ha0);
        chk(v, 8'h00, "unknown address");
        for (int k = 0; k < 4; k++) begin
            cmd({8'h1f, 8'hd0, (8'(rnd()) & 8'h9f) | 8'(k << 5), 8'h00}, 24);
            chk({6'h00, drv}, 8'(k), "drive pins");
            get(8'hd0);
            chk(v, 8'(k << 5), "drive read");
        end
        op(32'hff000000, 8, 8'h01, 8'h00);
        cmd(32'h06000000, 8);
        fs = 1'b1;
        op(32'h10000080, 32, 8'h03, 8'h0a);
        op(32'hd8000040, 32, 8'h0b, 8'h0e);
        fs = 1'b0;
        op(32'hd8000040, 32, 8'h0b, 8'h0a);
        op(32'h10000080, 32, 8'h03, 8'h02);
        cmd(32'h04000000, 8);
        op(32'h10000080, 32, 8'h00, 8'h00);
        cmd(32'h1fb00000, 24);
        @(posedge clk_i) col <= #1 12'h840;
        repeat (4) @(posedge clk_i);
        chk({een, wa, pr}, 8'h02, "ecc off");
        op(32'h13000040, 32, 8'h01, 8'h00);
        cmd(32'h1fb01000, 24);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i) col <= #1 cols[k];
            repeat (4) @(posedge clk_i);
            chk({wa, pr}, {6'h00, k < 5, 1'(6'b110100 >> k)}, "ecc map");
        end
        for (int k = 0; k < 8; k++) begin
            err = (k < 2) ? 4'h8 + 4'(k) : 4'(rnd() % 10);
            op(32'h13000040, 32, 8'h01, {2'b00, xecc(err) & 4'h3, 4'h0});
            get(8'hf0);
            chk(v, {2'b00, xecc(err) >> 2 & 4'h3, 4'h0} & {8{xecc(err) == 4'h1 || err < 8}}, "ext");
        end
        print_verdict();
    end
endmodule
